/* File: src/ach_pkg.sv */
// Constants, register map and carrier types of the axis command and status handshake.
// Assumes a single 125 MHz clock and a plain register port with one-cycle strobes.
package ach_pkg;

	// ==========================================================
	// Clock and motion timing.
	localparam int unsigned CLK_HZ              = 125_000_000;
	localparam int unsigned STEP_UM             = 10;
	localparam int unsigned HOME_SPEED_MM_PER_S = 20;
	localparam int unsigned HOME_STEPS_PER_S    = (HOME_SPEED_MM_PER_S * 1000) / STEP_UM;
	localparam int unsigned HOME_STEP_CYCLES    = CLK_HZ / HOME_STEPS_PER_S;
	localparam int unsigned MOVE_STEP_CYCLES    = 2500;

	// ==========================================================
	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_TARGET   = 8'h04;
	localparam logic [7:0] ADDR_BAND     = 8'h08;
	localparam logic [7:0] ADDR_OFFSET   = 8'h0C;
	localparam logic [7:0] ADDR_STATUS   = 8'h10;
	localparam logic [7:0] ADDR_POSITION = 8'h14;
	localparam logic [1:0] TABLE_PAGE    = 2'h1;

	// ==========================================================
	// Control fields and reset values.
	localparam int unsigned CTRL_DIRECT   = 0;
	localparam int unsigned CTRL_SVOFF_CL = 1;
	localparam int unsigned CTRL_BAND_CL  = 2;
	localparam logic [2:0]  CTRL_RST      = 3'h0;
	localparam logic [15:0] BAND_RST      = 16'h000A;
	localparam logic [15:0] OFFSET_RST    = 16'h0032;

	// ==========================================================
	// Carrier types.
	typedef struct packed {
		logic fault_clear;
		logic drive_enable;
		logic homing;
		logic position_go;
		logic pause;
	} ach_cmd_s;

	typedef struct packed {
		logic estop;
		logic alarm_cancel;
		logic alarm_cold;
		logic init_done;
		logic end_stop;
	} ach_plant_s;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SEEK = 4'h2,
		ST_BACK = 4'h4,
		ST_MOVE = 4'h8
	} ach_state_e;

endpackage : ach_pkg

/* File: src/ach_axis.sv */
// Per-axis command and status handshake with a simple stepping position model.
// Host commands and plant conditions arrive from outside the clock domain.
//
// Overview of operation
// - Separate axis bits; one asserted, zero deasserted.
// - Ready after init, regardless of alarm.
// - Emergency flag follows the emergency stop.
// - Alarms never raise the emergency flag.
// - Alarm flag rises on cancel-level alarms.
// - Fault clear removes cancel-level alarm.
// - Cold-start alarm survives fault clear.
// - Fault clear edge while paused discards move.
// - Servo on raises enabled and in-position together.
// - Enable drop stops hard, brake engages.
// - No in-position while paused.
// - Homing starts on rising edge only.
// - Homed holds until reference lost.
// - Homing: in-position low, moving high.
// - Homing seeks end, reverses by offset.
// - Go edge moves to index or register.
// - In-position drops when a move starts.
// - Held go withholds index and in-position.
// - Completion shows index with in-position.
// - Moving ends at in-position or command end.
// - In-position in band, configurable release.
// - Servo off drops in-position temporarily.
// - Completed index limited to 0..15.
// - Pause stops axis, release resumes.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps

module ach_axis #(
	parameter int unsigned HOME_STEP_CYCLES = ach_pkg::HOME_STEP_CYCLES,
	parameter int unsigned MOVE_STEP_CYCLES = ach_pkg::MOVE_STEP_CYCLES
) (
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Host commands and selected index.
	input  wire ach_pkg::ach_cmd_s   cmd_i,
	input  wire logic [3:0]       pos_index_i,
	// Plant conditions.
	input  wire ach_pkg::ach_plant_s plant_i,
	// Register port.
	input  wire logic [7:0]       addr_i,
	input  wire logic [31:0]      wr_data_i,
	input  wire logic             wr_en_i,
	input  wire logic             rd_en_i,
	output logic [31:0]           rd_data_o,
	// Status to host.
	output logic                  ctrl_ready_o,
	output logic                  emergency_stop_flag_o,
	output logic                  alarm_flag_o,
	output logic                  drive_enabled_stat_o,
	output logic                  in_position_stat_o,
	output logic                  homed_stat_o,
	output logic                  moving_stat_o,
	output logic [3:0]            done_index_bits_o,
	output logic                  axis_status_led_o,
	// Motor drive.
	output logic                  motor_step_o,
	output logic                  motor_dir_o,
	output logic                  brake_engage_o
);
	import ach_pkg::*;

	// ==========================================================
	// Helper functions.
	function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
		abs_diff = (a > b) ? (a - b) : (b - a);
	endfunction : abs_diff

	function automatic logic rise(input logic now, input logic prev);
		rise = now & ~prev;
	endfunction : rise

	// ==========================================================
	// Input synchronisers.
	ach_cmd_s   cmd_meta_reg;
	ach_cmd_s   cmd_reg;
	ach_cmd_s   cmd_prev_reg;
	ach_plant_s pl_meta_reg;
	ach_plant_s pl_reg;
	logic [3:0] idx_meta_reg;
	logic [3:0] idx_reg;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cmd_meta_reg <= '0;
			cmd_reg      <= '0;
			cmd_prev_reg <= '0;
			pl_meta_reg  <= '0;
			pl_reg       <= '0;
			idx_meta_reg <= 4'h0;
			idx_reg      <= 4'h0;
		end else begin
			cmd_meta_reg <= cmd_i;
			cmd_reg      <= cmd_meta_reg;
			cmd_prev_reg <= cmd_reg;
			pl_meta_reg  <= plant_i;
			pl_reg       <= pl_meta_reg;
			idx_meta_reg <= pos_index_i;
			idx_reg      <= idx_meta_reg;
		end
	end

	logic home_rise;
	logic go_rise;
	logic clear_rise;

	assign home_rise  = rise(cmd_reg.homing, cmd_prev_reg.homing);
	assign go_rise    = rise(cmd_reg.position_go, cmd_prev_reg.position_go);
	assign clear_rise = rise(cmd_reg.fault_clear, cmd_prev_reg.fault_clear);

	// ==========================================================
	// Software registers.
	logic [2:0]  ctrl_reg;
	logic [15:0] target_reg;
	logic [15:0] band_reg;
	logic [15:0] offset_reg;
	logic [15:0] table_mem [16];

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_reg   <= CTRL_RST;
			target_reg <= 16'h0000;
			band_reg   <= BAND_RST;
			offset_reg <= OFFSET_RST;
		end else if (wr_en_i) begin
			case (addr_i)
				ADDR_CTRL:   ctrl_reg   <= wr_data_i[2:0];
				ADDR_TARGET: target_reg <= wr_data_i[15:0];
				ADDR_BAND:   band_reg   <= wr_data_i[15:0];
				ADDR_OFFSET: offset_reg <= wr_data_i[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_en_i && addr_i[7:6] == TABLE_PAGE) begin
			table_mem[addr_i[5:2]] <= wr_data_i[15:0];
		end
	end

	// ==========================================================
	// Ready, alarm and servo state.
	logic ready_reg;
	logic alm_cancel_reg;
	logic alm_cold_reg;
	logic servo_reg;
	logic servo_next;
	logic alarm;

	assign alarm      = alm_cancel_reg | alm_cold_reg;
	assign servo_next = cmd_reg.drive_enable & ready_reg & ~pl_reg.estop & ~alarm;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ready_reg <= 1'b0;
		end else if (pl_reg.init_done) begin
			ready_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			alm_cancel_reg <= 1'b0;
			alm_cold_reg   <= 1'b0;
		end else begin
			if (pl_reg.alarm_cancel) begin
				alm_cancel_reg <= 1'b1;
			end else if (clear_rise) begin
				alm_cancel_reg <= 1'b0;
			end
			if (pl_reg.alarm_cold) begin
				alm_cold_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			servo_reg <= 1'b0;
		end else begin
			servo_reg <= servo_next;
		end
	end

	// ==========================================================
	// Step timing.
	logic [16:0] tick_cnt_reg;
	logic        tick;
	ach_state_e  state_reg;

	assign tick = (tick_cnt_reg == 17'h00000);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tick_cnt_reg <= 17'h00000;
		end else if (tick) begin
			if (state_reg == ST_MOVE) begin
				tick_cnt_reg <= 17'(MOVE_STEP_CYCLES - 1);
			end else begin
				tick_cnt_reg <= 17'(HOME_STEP_CYCLES - 1);
			end
		end else begin
			tick_cnt_reg <= tick_cnt_reg - 17'h00001;
		end
	end

	// ==========================================================
	// Motion sequencer.
	logic [15:0] pos_reg;
	logic [15:0] goal_reg;
	logic        done_reg;
	logic        homed_reg;
	logic        moving_reg;
	logic [3:0]  idx_latch_reg;
	logic        step_reg;
	logic        dir_reg;
	logic        halt;
	logic        paused;
	logic        in_band;
	logic        in_position_stat_next;
	logic        in_position_stat_reg;
	logic        step_now;

	assign halt     = pl_reg.estop | alarm | ~servo_reg;
	assign paused   = cmd_reg.pause & (state_reg != ST_IDLE);
	assign in_band  = abs_diff(pos_reg, goal_reg) <= band_reg;
	assign step_now = tick & ~paused;
	assign in_position_stat_next = done_reg & servo_reg & ~pl_reg.estop & ~cmd_reg.pause
		& ~cmd_reg.position_go & in_band;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg      <= ST_IDLE;
			pos_reg        <= 16'h0000;
			goal_reg       <= 16'h0000;
			done_reg       <= 1'b0;
			homed_reg      <= 1'b0;
			moving_reg     <= 1'b0;
			idx_latch_reg  <= 4'h0;
			step_reg       <= 1'b0;
			dir_reg        <= 1'b0;
		end else begin
			step_reg       <= 1'b0;
			if (alarm) begin
				homed_reg <= 1'b0;
			end
			if (in_position_stat_next) begin
				moving_reg <= 1'b0;
			end
			if (rise(servo_next, servo_reg) && !done_reg && state_reg == ST_IDLE) begin
				goal_reg <= pos_reg;
				done_reg <= 1'b1;
			end else if (!servo_reg && ctrl_reg[CTRL_SVOFF_CL]) begin
				done_reg <= 1'b0;
			end else if (state_reg == ST_IDLE && !in_band && ctrl_reg[CTRL_BAND_CL]) begin
				done_reg <= 1'b0;
			end
			case (state_reg)
				ST_IDLE: begin
					moving_reg <= 1'b0;
					if (!halt && home_rise) begin
						state_reg  <= ST_SEEK;
						done_reg   <= 1'b0;
						homed_reg  <= 1'b0;
						moving_reg <= 1'b1;
					end else if (!halt && go_rise) begin
						state_reg     <= ST_MOVE;
						done_reg      <= 1'b0;
						moving_reg    <= 1'b1;
						idx_latch_reg <= idx_reg;
						if (ctrl_reg[CTRL_DIRECT]) begin
							goal_reg <= target_reg;
						end else begin
							goal_reg <= table_mem[idx_reg];
						end
					end
				end
				ST_SEEK: begin
					if (halt || (paused && clear_rise)) begin
						state_reg <= ST_IDLE;
					end else if (pl_reg.end_stop) begin
						state_reg <= ST_BACK;
						pos_reg   <= 16'h0000;
						goal_reg  <= offset_reg;
					end else if (step_now) begin
						pos_reg  <= pos_reg - 16'h0001;
						step_reg <= 1'b1;
						dir_reg  <= 1'b0;
					end
				end
				ST_BACK: begin
					if (halt || (paused && clear_rise)) begin
						state_reg <= ST_IDLE;
					end else if (pos_reg == goal_reg) begin
						state_reg <= ST_IDLE;
						pos_reg   <= 16'h0000;
						goal_reg  <= 16'h0000;
						homed_reg <= 1'b1;
						done_reg  <= 1'b1;
					end else if (step_now) begin
						pos_reg  <= pos_reg + 16'h0001;
						step_reg <= 1'b1;
						dir_reg  <= 1'b1;
					end
				end
				ST_MOVE: begin
					if (in_band) begin
						done_reg <= 1'b1;
					end
					if (halt || (paused && clear_rise)) begin
						state_reg <= ST_IDLE;
						if (!in_band) begin
							goal_reg <= pos_reg;
						end
					end else if (pos_reg == goal_reg) begin
						state_reg  <= ST_IDLE;
						moving_reg <= 1'b0;
					end else if (step_now) begin
						step_reg <= 1'b1;
						dir_reg  <= (goal_reg > pos_reg);
						if (goal_reg > pos_reg) begin
							pos_reg <= pos_reg + 16'h0001;
						end else begin
							pos_reg <= pos_reg - 16'h0001;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Status outputs, all updated together.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			in_position_stat_reg              <= 1'b0;
			ctrl_ready_o          <= 1'b0;
			emergency_stop_flag_o <= 1'b0;
			alarm_flag_o          <= 1'b0;
			drive_enabled_stat_o  <= 1'b0;
			in_position_stat_o    <= 1'b0;
			homed_stat_o          <= 1'b0;
			moving_stat_o         <= 1'b0;
			done_index_bits_o     <= 4'h0;
			axis_status_led_o     <= 1'b0;
			motor_step_o          <= 1'b0;
			motor_dir_o           <= 1'b0;
			brake_engage_o        <= 1'b1;
		end else begin
			in_position_stat_reg              <= in_position_stat_next;
			ctrl_ready_o          <= ready_reg;
			emergency_stop_flag_o <= pl_reg.estop;
			alarm_flag_o          <= alarm;
			drive_enabled_stat_o  <= servo_reg;
			in_position_stat_o    <= in_position_stat_next;
			homed_stat_o          <= homed_reg;
			moving_stat_o         <= moving_reg & ~in_position_stat_next;
			axis_status_led_o     <= servo_reg;
			motor_step_o          <= step_reg;
			motor_dir_o           <= dir_reg;
			brake_engage_o        <= ~servo_reg;
			if (in_position_stat_next && !in_position_stat_reg) begin
				done_index_bits_o <= idx_latch_reg;
			end
		end
	end

	// ==========================================================
	// Register read port.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_data_o <= 32'h00000000;
		end else if (rd_en_i) begin
			if (addr_i[7:6] == TABLE_PAGE) begin
				rd_data_o <= {16'h0000, table_mem[addr_i[5:2]]};
			end else begin
				case (addr_i)
					ADDR_CTRL:     rd_data_o <= {29'h0000000, ctrl_reg};
					ADDR_TARGET:   rd_data_o <= {16'h0000, target_reg};
					ADDR_BAND:     rd_data_o <= {16'h0000, band_reg};
					ADDR_OFFSET:   rd_data_o <= {16'h0000, offset_reg};
					ADDR_STATUS:   rd_data_o <= {16'h0000, state_reg, idx_latch_reg, alm_cold_reg,
						alm_cancel_reg, done_reg, homed_reg, moving_reg, servo_reg, pl_reg.estop, ready_reg};
					ADDR_POSITION: rd_data_o <= {16'h0000, pos_reg};
					default:       rd_data_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule : ach_axis

/* File: testbench/ach_axis_asserts.sv */
// Concurrent checks on the ports of the axis command and status handshake.
// Assumes one clock, a synchronous active-low reset and two-flop input synchronisers in the design.
`timescale 1ns/100ps

module ach_axis_asserts #(
	parameter int unsigned HOME_STEP_CYCLES = 4,
	parameter int unsigned MOVE_STEP_CYCLES = 2
) (
	// Clock, reset and inputs.
	input wire logic               clk_i,
	input wire logic               rst_n_i,
	input wire ach_pkg::ach_cmd_s   cmd_i,
	input wire ach_pkg::ach_plant_s plant_i,
	// Status outputs.
	input wire logic               ctrl_ready_o,
	input wire logic               emergency_stop_flag_o,
	input wire logic               alarm_flag_o,
	input wire logic               drive_enabled_stat_o,
	input wire logic               in_position_stat_o,
	input wire logic               homed_stat_o,
	input wire logic               moving_stat_o,
	input wire logic [3:0]         done_index_bits_o,
	input wire logic               brake_engage_o
);
	import ach_pkg::*;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// ==========================================================
	// Sequences.
	sequence s_go_edge;
		!cmd_i.position_go ##1 cmd_i.position_go;
	endsequence
	sequence s_ready_idle;
		drive_enabled_stat_o && in_position_stat_o && !alarm_flag_o && !emergency_stop_flag_o && !cmd_i.pause;
	endsequence

	// ==========================================================
	// Properties.
	a_ready_sticky: assert property (ctrl_ready_o |=> ctrl_ready_o)
		else $error("Ready flag dropped.");
	a_estop_rise: assert property ($rose(plant_i.estop) |-> ##[2:5] emergency_stop_flag_o)
		else $error("Emergency flag late.");
	a_estop_only: assert property (!plant_i.estop [*5] |-> !emergency_stop_flag_o)
		else $error("Emergency flag without emergency stop.");
	a_alarm_rise: assert property ($rose(plant_i.alarm_cancel) |-> ##[2:5] alarm_flag_o)
		else $error("Alarm flag late.");
	a_servo_in_position_stat: assert property ($rose(drive_enabled_stat_o) && !cmd_i.pause && !alarm_flag_o
		|-> in_position_stat_o)
		else $error("Servo on without in-position.");
	a_brake_servo: assert property (!drive_enabled_stat_o |-> brake_engage_o)
		else $error("Brake free while servo off.");
	a_pause_in_position_stat: assert property (cmd_i.pause [*6] |-> !in_position_stat_o)
		else $error("In-position while paused.");
	a_home_start: assert property ($rose(cmd_i.homing) ##0 s_ready_idle
		|-> ##[2:6] (moving_stat_o && !in_position_stat_o))
		else $error("Homing did not start.");
	a_homed_hold: assert property ($fell(homed_stat_o) |-> ##[0:2] alarm_flag_o)
		else $error("Homed lost without alarm.");
	a_go_start: assert property (s_go_edge ##0 s_ready_idle |-> ##[2:6] !in_position_stat_o)
		else $error("In-position kept at move start.");
	a_go_held: assert property (cmd_i.position_go [*4]
		|-> !$rose(in_position_stat_o) && $stable(done_index_bits_o))
		else $error("Completion shown while go held.");
	a_move_in_position_stat: assert property (moving_stat_o |-> !in_position_stat_o)
		else $error("Moving together with in-position.");

endmodule : ach_axis_asserts

bind ach_axis ach_axis_asserts #(
	.HOME_STEP_CYCLES(HOME_STEP_CYCLES),
	.MOVE_STEP_CYCLES(MOVE_STEP_CYCLES)
) u_asserts (
	.clk_i                (clk_i),
	.rst_n_i              (rst_n_i),
	.cmd_i                (cmd_i),
	.plant_i              (plant_i),
	.ctrl_ready_o         (ctrl_ready_o),
	.emergency_stop_flag_o(emergency_stop_flag_o),
	.alarm_flag_o         (alarm_flag_o),
	.drive_enabled_stat_o (drive_enabled_stat_o),
	.in_position_stat_o   (in_position_stat_o),
	.homed_stat_o         (homed_stat_o),
	.moving_stat_o        (moving_stat_o),
	.done_index_bits_o    (done_index_bits_o),
	.brake_engage_o       (brake_engage_o)
);

/* File: testbench/ach_plant_model.sv */
// Behavioural plant: mechanical position, hard end stop and condition inputs.
// Assumes step pulses one cycle long and direction high for increasing position.
`timescale 1ns/100ps

module ach_plant_model #(
	parameter int END_DIST = 20
) (
	input  wire logic      clk_i,
	input  wire logic      step_i,
	input  wire logic      dir_i,
	input  wire logic      estop_i,
	input  wire logic      alarm_cancel_i,
	input  wire logic      alarm_cold_i,
	output ach_pkg::ach_plant_s plant_o,
	output int             mech_pos_o
);
	import ach_pkg::*;

	int init_cnt = 0;

	// ==========================================================
	// Mechanics.
	initial mech_pos_o = END_DIST;
	always @(posedge clk_i) begin
		if (init_cnt < 4)
			init_cnt <= init_cnt + 1;
		if (step_i && dir_i)
			mech_pos_o <= mech_pos_o + 1;
		else if (step_i && mech_pos_o > 0)
			mech_pos_o <= mech_pos_o - 1;
	end
	assign plant_o = {estop_i, alarm_cancel_i, alarm_cold_i, init_cnt == 4, mech_pos_o == 0};
endmodule : ach_plant_model

/* File: testbench/axis_command_status_handshake_test.sv */
// Self-checking bench for the axis handshake: register port tasks and command sequences.
// Assumes short step counts and the plant model on the condition inputs.
`timescale 1ns/100ps
`define CHK(a, b) begin \
	compares++; \
	if ((a) !== (b)) begin \
		bad_count++; \
		$display("CHECK FAILED at %0t: got %0h expected %0h", $time, (a), (b)); \
	end \
end
`define WAITC(c) begin \
	int k; \
	for (k = 0; k < 3000 && !(c); k++) begin \
		@(posedge clk_i); \
		#1; \
	end \
	if (!(c)) begin \
		bad_count++; \
		$display("CHECK FAILED at %0t: wait timed out", $time); \
		end_of_test(); \
	end \
end

module axis_command_status_handshake_test;
	import ach_pkg::*;

	logic       clk_i, rst_n_i, wr_en_i, rd_en_i, estop, alm_c, alm_cold;
	ach_cmd_s   cmd_i;
	ach_plant_s plant_i;
	logic [3:0] pos_index_i, done_index_bits_o;
	logic [7:0] addr_i;
	logic [31:0] wr_data_i, rd_data_o;
	logic       ctrl_ready_o, emergency_stop_flag_o, alarm_flag_o, drive_enabled_stat_o, in_position_stat_o;
	logic       homed_stat_o, moving_stat_o, axis_status_led_o, motor_step_o, motor_dir_o, brake_engage_o;
	int         mech_pos, held, bad_count, compares;

	ach_axis #(.HOME_STEP_CYCLES(4), .MOVE_STEP_CYCLES(2)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i),
		.pos_index_i(pos_index_i), .plant_i(plant_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
		.rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .ctrl_ready_o(ctrl_ready_o),
		.emergency_stop_flag_o(emergency_stop_flag_o), .alarm_flag_o(alarm_flag_o),
		.drive_enabled_stat_o(drive_enabled_stat_o), .in_position_stat_o(in_position_stat_o),
		.homed_stat_o(homed_stat_o), .moving_stat_o(moving_stat_o), .done_index_bits_o(done_index_bits_o),
		.axis_status_led_o(axis_status_led_o), .motor_step_o(motor_step_o), .motor_dir_o(motor_dir_o),
		.brake_engage_o(brake_engage_o));
	ach_plant_model u_plant (.clk_i(clk_i), .step_i(motor_step_o), .dir_i(motor_dir_o), .estop_i(estop),
		.alarm_cancel_i(alm_c), .alarm_cold_i(alm_cold), .plant_o(plant_i), .mech_pos_o(mech_pos));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// ==========================================================
	// Tasks.
	task automatic end_of_test;
		if (bad_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1'b1;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1;
		`CHK(rd_data_o, e)
	endtask : reg_rd

	task automatic pulse_clear;
		repeat (4) @(posedge clk_i);
		cmd_i.fault_clear <= 1'b1;
		repeat (4) @(posedge clk_i);
		cmd_i.fault_clear <= 1'b0;
	endtask : pulse_clear

	task automatic do_reset;
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1;
	endtask : do_reset

	// ==========================================================
	// Sequence of tests.
	initial begin
		{rst_n_i, wr_en_i, rd_en_i, estop, alm_c, alm_cold} = '0;
		{cmd_i, pos_index_i, addr_i, wr_data_i} = '0;
		do_reset();
		`CHK({ctrl_ready_o, brake_engage_o}, 2'b01)
		reg_rd(ADDR_CTRL, 32'h0);
		reg_rd(ADDR_BAND, 32'h0000_000A);
		reg_rd(ADDR_OFFSET, 32'h0000_0032);
		reg_rd(8'h20, 32'h0);
		`WAITC(ctrl_ready_o)
		alm_c <= 1'b1;
		`WAITC(alarm_flag_o)
		`CHK({ctrl_ready_o, emergency_stop_flag_o}, 2'b10)
		alm_c <= 1'b0;
		pulse_clear();
		`WAITC(!alarm_flag_o)
		estop <= 1'b1;
		`WAITC(emergency_stop_flag_o)
		`CHK(alarm_flag_o, 1'b0)
		estop <= 1'b0;
		`WAITC(!emergency_stop_flag_o)
		alm_cold <= 1'b1;
		`WAITC(alarm_flag_o)
		alm_cold <= 1'b0;
		pulse_clear();
		repeat (10) @(posedge clk_i);
		#1;
		`CHK(alarm_flag_o, 1'b1)
		do_reset();
		`CHK(alarm_flag_o, 1'b0)
		`WAITC(ctrl_ready_o)
		reg_wr(ADDR_OFFSET, 32'h5);
		cmd_i.drive_enable <= 1'b1;
		`WAITC(drive_enabled_stat_o)
		`CHK({in_position_stat_o, brake_engage_o, axis_status_led_o}, 3'b101)
		cmd_i.homing <= 1'b1;
		`WAITC(moving_stat_o)
		`CHK(in_position_stat_o, 1'b0)
		`WAITC(homed_stat_o)
		repeat (20) @(posedge clk_i);
		#1;
		`CHK({moving_stat_o, in_position_stat_o}, 2'b01)
		`CHK(mech_pos, 5)
		reg_rd(ADDR_POSITION, 32'h0);
		cmd_i.homing <= 1'b0;
		reg_wr(8'h4C, 32'h8);
		pos_index_i <= 4'h3;
		cmd_i.position_go <= 1'b1;
		`WAITC(moving_stat_o)
		`CHK(in_position_stat_o, 1'b0)
		repeat (40) @(posedge clk_i);
		#1;
		`CHK({in_position_stat_o, done_index_bits_o}, 5'h00)
		cmd_i.position_go <= 1'b0;
		`WAITC(in_position_stat_o)
		`CHK({moving_stat_o, done_index_bits_o}, 5'h03)
		reg_rd(ADDR_POSITION, 32'h8);
		reg_wr(ADDR_CTRL, 32'h1);
		reg_wr(ADDR_TARGET, 32'h2);
		pos_index_i <= 4'hF;
		cmd_i.position_go <= 1'b1;
		`WAITC(moving_stat_o)
		cmd_i.position_go <= 1'b0;
		`WAITC(in_position_stat_o)
		`CHK(done_index_bits_o, 4'hF)
		`WAITC(mech_pos == 5 + 2)
		reg_rd(ADDR_POSITION, 32'h2);
		cmd_i.drive_enable <= 1'b0;
		`WAITC(!drive_enabled_stat_o)
		`CHK({in_position_stat_o, brake_engage_o}, 2'b01)
		cmd_i.drive_enable <= 1'b1;
		`WAITC(drive_enabled_stat_o)
		`CHK(in_position_stat_o, 1'b1)
		reg_wr(ADDR_TARGET, 32'h3C);
		cmd_i.position_go <= 1'b1;
		`WAITC(moving_stat_o)
		cmd_i.position_go <= 1'b0;
		cmd_i.pause <= 1'b1;
		repeat (10) @(posedge clk_i);
		#1;
		`CHK(in_position_stat_o, 1'b0)
		pulse_clear();
		repeat (6) @(posedge clk_i);
		cmd_i.pause <= 1'b0;
		held = mech_pos;
		repeat (200) @(posedge clk_i);
		#1;
		`CHK({moving_stat_o, mech_pos}, {1'b0, held})
		alm_c <= 1'b1;
		`WAITC(!homed_stat_o)
		`CHK(alarm_flag_o, 1'b1)
		end_of_test();
	end
endmodule : axis_command_status_handshake_test
